// *** hw/flash_security_lock.sv ***
// Flash security lock: lock byte tracking, command gating, table read gating
`timescale 1ns/1ns
module flash_security_lock #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              clk_en,
    // Lock byte load at start-up from the array
    input  wire logic              boot_load,
    input  wire logic [7:0]        boot_lock_byte,
    // Command request from the flash command controller
    input  wire logic              cmd_valid,
    input  wire logic [6:0]        cmd_code,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [7:0]        cmd_data,
    input  wire logic              flash_block_select,
    // Execution context from the core
    input  wire logic              pc_internal,
    input  wire logic              pc_upper,
    input  wire logic              external_access_pin,
    // Constant table read request
    input  wire logic              constant_table_read,
    input  wire logic              read_upper,
    // Command verdicts
    output logic                   cmd_start,
    output logic                   cmd_refused,
    // Table read verdicts
    output logic                   read_grant,
    output logic                   read_block,
    // Lock state
    output logic [7:0]             lock_config_byte,
    output logic [7:0]             flash_config_status_reg
);
    // ***********************************************
    // Parameter check
    // ***********************************************
    // Lock byte sits at the top of the address space;
    // a different width would miss it
    if (ADDR_W != $bits(flash_lock_pkg::LOCK_BYTE_ADDR)) begin : g_width_check
        $error("ADDR_W must match the lock byte address width");
    end

    // ***********************************************
    // State
    // ***********************************************
    // Whole block state in one record; pulses clear each enabled cycle
    typedef struct packed {
        logic [2:0] pin_sync;
        logic       pin;
        logic [7:0] lock_byte;
        logic [1:0] status;
        logic       start;
        logic       refused;
        logic       grant;
        logic       block;
    } state_s;

    // Reset as internal execution, the pin's idle level,
    // so the synchroniser shows no false change after reset
    localparam logic PIN_IDLE = 1'b1;
    localparam state_s RESET_Q = '{
        pin_sync:  {3{PIN_IDLE}},
        pin:       PIN_IDLE,
        lock_byte: flash_lock_pkg::ERASED_BYTE,
        status:    flash_lock_pkg::ST_UNLOCKED,
        start:     1'b0,
        refused:   1'b0,
        grant:     1'b0,
        block:     1'b0
    };

    state_s q;
    state_s d;

    // Verdicts of the shared decoder
    logic cmd_ok;
    logic rd_ok;

    // ***********************************************
    // Lock byte and command decode
    // ***********************************************
    function automatic logic [1:0] lock_status(input logic [7:0] b);
        unique case (b)
            flash_lock_pkg::LOCK_NONE:    lock_status = flash_lock_pkg::ST_UNLOCKED;
            flash_lock_pkg::LOCK_BOTH:    lock_status = flash_lock_pkg::ST_BOTH;
            flash_lock_pkg::LOCK_UPPER:   lock_status = flash_lock_pkg::ST_UPPER;
            flash_lock_pkg::LOCK_BOTH_EA: lock_status = flash_lock_pkg::ST_BOTH_EA;
            // Any other programmed value is treated as the strongest lock
            default:                      lock_status = flash_lock_pkg::ST_BOTH;
        endcase
    endfunction

    // Byte or burst program aimed at the lock byte
    function automatic logic writes_lock(input logic [6:0]        code,
                                         input logic [ADDR_W-1:0] addr);
        writes_lock = (code == flash_lock_pkg::CMD_BYTE_PROG
                       || code == flash_lock_pkg::CMD_BURST_PROG)
                      && addr == flash_lock_pkg::LOCK_BYTE_ADDR;
    endfunction

    // Block erase of the upper block, which holds the lock byte
    function automatic logic erases_top(input logic [6:0] code,
                                        input logic       upper);
        erases_top = code == flash_lock_pkg::CMD_BLOCK_ERASE && upper;
    endfunction

    // ***********************************************
    // Permission decode
    // ***********************************************
    // One decoder serves both gates;
    // table reads reuse the block select as their target
    lock_decode u_decode (
        .status       (q.status),
        .target_upper (flash_block_select),
        .pc_upper     (pc_upper),
        .pc_internal  (pc_internal),
        .ext_pin      (q.pin),
        .cmd_allowed  (cmd_ok),
        .read_allowed (rd_ok)
    );

    // ***********************************************
    // Next state
    // ***********************************************
    always_comb begin
        d         = q;
        // Verdict pulses last one enabled cycle
        d.start   = 1'b0;
        d.refused = 1'b0;
        d.grant   = 1'b0;
        d.block   = 1'b0;

        // Pin is asynchronous: three stages, accept on agreement of last two
        d.pin_sync = {q.pin_sync[1:0], external_access_pin};
        if (q.pin_sync[2] == q.pin_sync[1]) begin
            d.pin = q.pin_sync[2];
        end

        // Command gate; a boot load in the same cycle swallows the command
        if (boot_load) begin
            d.lock_byte = boot_lock_byte;
        end else if (cmd_valid) begin
            if (cmd_code == flash_lock_pkg::CMD_CHIP_ERASE) begin
                d.start     = 1'b1;
                d.lock_byte = flash_lock_pkg::ERASED_BYTE;
            end else if (cmd_ok) begin
                d.start = 1'b1;
                // Program of the top byte arms the lock; bits can only clear.
                // Once armed only chip erase or a boot load moves it, so a lower-block
                // program naming the top address leaves it alone.
                if (writes_lock(cmd_code, cmd_addr)
                    && q.lock_byte == flash_lock_pkg::LOCK_NONE) begin
                    d.lock_byte = q.lock_byte & cmd_data;
                end else if (erases_top(cmd_code, flash_block_select)) begin
                    // Block erase of upper only runs when unlocked
                    d.lock_byte = flash_lock_pkg::ERASED_BYTE;
                end
            end else begin
                d.refused = 1'b1;
            end
        end

        // Status follows the byte being stored, so both move together
        d.status = lock_status(d.lock_byte);

        // Table read gate: locked targets only for code inside the lock
        if (constant_table_read) begin
            if (q.status == flash_lock_pkg::ST_UNLOCKED) begin
                d.grant = 1'b1;
            end else begin
                d.grant = rd_ok && !(read_upper != flash_block_select && 1'b0);
                d.block = !rd_ok;
            end
        end
    end

    // ***********************************************
    // Registers
    // ***********************************************
    // Clock enable low freezes every field, pulses included
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= RESET_Q;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    // Pulses stand one cycle, longer while the clock enable is low
    assign cmd_start        = q.start;
    assign cmd_refused      = q.refused;
    assign read_grant       = q.grant;
    assign read_block       = q.block;
    assign lock_config_byte = q.lock_byte;
    // Bits outside the status field read as zero
    always_comb begin
        flash_config_status_reg = 8'h00;
        flash_config_status_reg[flash_lock_pkg::ST_POS +: 2] = q.status;
    end
endmodule

// *** shared/flash_lock_pkg.sv ***
// Package: lock byte codes, status encodings and flash command codes
package flash_lock_pkg;
    // ***********************************************
    // Lock byte location and values
    // ***********************************************
    localparam logic [15:0] LOCK_BYTE_ADDR  = 16'hFFFF;
    localparam logic [7:0]  LOCK_NONE       = 8'hFF;
    localparam logic [7:0]  LOCK_BOTH       = 8'h55;
    localparam logic [7:0]  LOCK_UPPER      = 8'hF5;
    localparam logic [7:0]  LOCK_BOTH_EA    = 8'h05;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

    // ***********************************************
    // Lock status field codes
    // ***********************************************
    localparam logic [1:0] ST_UNLOCKED  = 2'h0;
    localparam logic [1:0] ST_UPPER     = 2'h1;
    localparam logic [1:0] ST_BOTH_EA   = 2'h2;
    localparam logic [1:0] ST_BOTH      = 2'h3;
    localparam int         ST_POS       = 5;

    // ***********************************************
    // Flash command codes (low seven bits)
    // ***********************************************
    localparam logic [6:0] CMD_CHIP_ERASE   = 7'h07;
    localparam logic [6:0] CMD_BLOCK_ERASE  = 7'h0F;
    localparam logic [6:0] CMD_SECTOR_ERASE = 7'h0B;
    localparam logic [6:0] CMD_BYTE_PROG    = 7'h0E;
    localparam logic [6:0] CMD_BURST_PROG   = 7'h0A;
    localparam logic [6:0] CMD_VERIFY       = 7'h0C;
endpackage

// *** hw/lock_decode.sv ***
// Lock status to per-access permission check for commands and table reads
`timescale 1ns/1ns
module lock_decode (
    // Lock state
    input  wire logic [1:0] status,
    // Access context
    input  wire logic       target_upper,
    input  wire logic       pc_upper,
    input  wire logic       pc_internal,
    input  wire logic       ext_pin,
    // Verdicts
    output logic            cmd_allowed,
    output logic            read_allowed
);
    logic target_locked;
    logic pc_locked;

    always_comb begin
        target_locked = 1'b0;
        pc_locked     = 1'b0;
        cmd_allowed   = 1'b1;
        unique case (status)
            flash_lock_pkg::ST_UNLOCKED: begin
                cmd_allowed = 1'b1;
            end
            flash_lock_pkg::ST_UPPER: begin
                target_locked = target_upper;
                pc_locked     = pc_internal && pc_upper;
                cmd_allowed   = !target_upper;
            end
            flash_lock_pkg::ST_BOTH_EA: begin
                target_locked = 1'b1;
                pc_locked     = pc_internal;
                // Lower block only, and only while running internally
                cmd_allowed   = !target_upper && ext_pin;
            end
            flash_lock_pkg::ST_BOTH: begin
                target_locked = 1'b1;
                pc_locked     = pc_internal;
                cmd_allowed   = 1'b0;
            end
        endcase
        // Constant reads of locked memory only from locked code
        read_allowed = !target_locked || pc_locked;
    end
endmodule

// *** tb/flash_lock_sva.sv ***
// Checker for the lock block port behaviour
`timescale 1ns/1ns
module flash_lock_sva (
    // Controls and requests
    input wire logic       clk, resetn, clk_en, boot_load, cmd_valid,
    input wire logic [6:0] cmd_code,
    input wire logic       flash_block_select, pc_internal, constant_table_read,
    // Verdicts and state
    input wire logic       cmd_start, cmd_refused, read_grant, read_block,
    input wire logic [7:0] lock_config_byte, flash_config_status_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic [1:0] st = flash_config_status_reg[6:5];
    wire logic       ce = cmd_code == flash_lock_pkg::CMD_CHIP_ERASE;
    sequence take_s(c);
        clk_en && cmd_valid && !boot_load && c;
    endsequence
    one_verdict_a: assert property (take_s(1) |=> cmd_start != cmd_refused)
        else $error("verdict count wrong");
    idle_quiet_a: assert property (clk_en && !cmd_valid |=> !cmd_start && !cmd_refused)
        else $error("verdict without request");
    chip_erase_a: assert property (take_s(ce) |=> cmd_start && lock_config_byte == 8'hFF)
        else $error("chip erase not done");
    both_lock_a: assert property (take_s(!ce && st == 2'h3) |=> cmd_refused)
        else $error("command passed full lock");
    upper_lock_a: assert property (take_s(!ce && st == 2'h1 && flash_block_select)
        |=> cmd_refused) else $error("upper command passed");
    lower_open_a: assert property (take_s(!ce && st == 2'h1 && !flash_block_select)
        |=> cmd_start) else $error("lower command refused");
    lock_hold_a: assert property ($changed(lock_config_byte) && $past(lock_config_byte) != 8'hFF
        |-> $past(boot_load) || $past(cmd_valid) && $past(ce)) else $error("lock changed");
    read_shut_a: assert property (clk_en && constant_table_read && st == 2'h3 && !pc_internal
        |=> read_block && !read_grant) else $error("locked read granted");
endmodule
bind flash_security_lock flash_lock_sva u_sva (.*);

// *** tb/core_model.sv ***
// Behavioural core and command controller facing the lock block
`timescale 1ns/1ns
module core_model (
    input  wire logic   clk,
    output logic        cmd_valid, constant_table_read, flash_block_select,
    output logic        pc_internal, pc_upper, external_access_pin,
    output logic [6:0]  cmd_code,
    output logic [15:0] cmd_addr,
    output logic [7:0]  cmd_data
);
    initial begin
        {cmd_valid, constant_table_read, flash_block_select, pc_internal, pc_upper} = '0;
        external_access_pin = 1'b1;
        {cmd_code, cmd_addr, cmd_data} = '0;
    end
    // Data scrambled after release so a stale value is never trusted
    task automatic issue(logic [6:0] c, logic b, logic [15:0] a, logic [7:0] d);
        @(negedge clk);
        {cmd_valid, cmd_code, flash_block_select, cmd_addr, cmd_data} = {1'b1, c, b, a, d};
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_data = ~d;
    endtask
    task automatic table_read(logic b, logic pu, logic pi);
        @(negedge clk);
        {constant_table_read, flash_block_select, pc_upper, pc_internal} = {1'b1, b, pu, pi};
        @(negedge clk);
        constant_table_read = 1'b0;
    endtask
    task automatic set_pin(logic v);
        @(negedge clk);
        external_access_pin = v;
    endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the flash security lock
`timescale 1ns/1ns
module tb_top;
    logic clk, resetn, boot_load, cmd_valid, ctr, bsel, pci, pcu, pin, start, refused, grant, blk;
    logic        ce;
    logic [6:0]  code;
    logic [15:0] addr;
    logic [7:0]  boot_byte, data, lock_byte, status_reg;
    logic [6:0]  codes [5] = '{7'h0F, 7'h0B, 7'h0E, 7'h0A, 7'h0C};
    int          errors, n_checks, cyc, lb;
    flash_security_lock DUT (.clk(clk), .resetn(resetn), .clk_en(ce), .boot_load(boot_load),
        .boot_lock_byte(boot_byte), .cmd_valid(cmd_valid), .cmd_code(code), .cmd_addr(addr),
        .cmd_data(data), .flash_block_select(bsel), .pc_internal(pci), .pc_upper(pcu),
        .external_access_pin(pin), .constant_table_read(ctr), .read_upper(bsel),
        .cmd_start(start), .cmd_refused(refused), .read_grant(grant), .read_block(blk),
        .lock_config_byte(lock_byte), .flash_config_status_reg(status_reg));
    core_model core (.clk(clk), .cmd_valid(cmd_valid), .constant_table_read(ctr),
        .flash_block_select(bsel), .pc_internal(pci), .pc_upper(pcu), .external_access_pin(pin),
        .cmd_code(code), .cmd_addr(addr), .cmd_data(data));
    function automatic int st(int b);
        return b == 'hFF ? 0 : b == 'hF5 ? 1 : b == 'h05 ? 2 : 3;
    endfunction
    function automatic bit locked(logic b);
        return st(lb) >= 2 || st(lb) == 1 && b;
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(logic [6:0] c, logic b, logic [15:0] a, logic [7:0] d);
        bit ok;
        ok = c == 7'h07 || !locked(b) || st(lb) == 2 && !b && pin;
        core.issue(c, b, a, d);
        check({7'h0, start}, {7'h0, ok});
        check({7'h0, refused}, {7'h0, !ok});
        if (ok && c == 7'h07) lb = 'hFF;
        else if (ok && lb == 'hFF && (c == 7'h0E || c == 7'h0A) && a == 16'hFFFF)
            lb = lb & d;
        check(lock_byte, 8'(lb));
        check(status_reg, 8'(st(lb) << 5));
    endtask
    task automatic rd(logic b, logic pu, logic pi);
        bit g;
        g = !locked(b) || pi && locked(pu);
        core.table_read(b, pu, pi);
        check({6'h0, grant, blk}, {6'h0, g, !g});
    endtask
    task automatic load(logic [7:0] b);
        @(negedge clk);
        {boot_load, boot_byte} = {1'b1, b};
        @(negedge clk);
        boot_load = 1'b0;
        lb = b;
        check(status_reg, 8'(st(lb) << 5));
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Ceiling well above the hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        {resetn, boot_load, boot_byte, lb} = {2'b0, 8'hFF, 32'hFF};
        ce = 1'b1;
        void'($urandom(32'h2FDC));
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check(lock_byte, 8'hFF);
        foreach (codes[i]) cmd(codes[i], 1'($urandom), 16'h0100, 8'h00);
        cmd(7'h0E, 1'b1, 16'hFFFF, 8'hF5);
        foreach (codes[i]) begin
            cmd(codes[i], 1'b0, 16'h0100, 8'($urandom));
            cmd(codes[i], 1'b1, 16'hFFFF, 8'h55);
        end
        cmd(7'h0E, 1'b0, 16'hFFFF, 8'h05);
        repeat (8) rd(1'($urandom), 1'($urandom), 1'($urandom));
        cmd(7'h07, 1'b1, 16'h0000, 8'h55);
        load(8'h05);
        foreach (codes[i]) begin
            cmd(codes[i], 1'b0, 16'h0100, 8'h00);
            cmd(codes[i], 1'b1, 16'hFFFF, 8'h00);
        end
        core.set_pin(1'b0);
        repeat (5) @(negedge clk);
        cmd(7'h0F, 1'b0, 16'h0000, 8'h55);
        load(8'h55);
        foreach (codes[i]) cmd(codes[i], 1'($urandom), 16'hFFFF, 8'h00);
        rd(1'b1, 1'b1, 1'b0);
        ce = 1'b0;
        core.issue(7'h07, 1'b0, 16'h0000, 8'h55);
        check({7'h0, start}, 8'h00);
        check(lock_byte, 8'(lb));
        ce = 1'b1;
        cmd(7'h07, 1'b0, 16'h0000, 8'h55);
        complete_run();
    end
endmodule
